// *** hdl/bcs_map.vh ***
// Constants for the codeword status bank: offsets, field positions, widths.
// Assumes inclusion by bcs_status_bank.v and bcs_ahb_slave.v only.
`ifndef BCS_MAP_VH
`define BCS_MAP_VH

// ----------------------------------------
// Bus decode
// ----------------------------------------
`define BCS_ADDR_W 12
`define BCS_HTRANS_NONSEQ 2'h2
`define BCS_HSIZE_WORD 3'h2
`define BCS_RESP_OKAY 1'h0

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BCS_OFF_CW_8_9 12'h0160
`define BCS_OFF_CW_10_11 12'h0164
`define BCS_OFF_CW_12_13 12'h0168
`define BCS_OFF_CW_14_15 12'h016c
`define BCS_OFF_CW_16_17 12'h0170
`define BCS_OFF_CW_18_19 12'h0174
`define BCS_OFF_CW_20_21 12'h0178
`define BCS_OFF_INT_STATUS 12'h01f0
`define BCS_OFF_INT_MASK 12'h01f4
`define BCS_WORD_STEP 12'h0004

// ----------------------------------------
// Codeword range held in the bank
// ----------------------------------------
`define BCS_CW_FIRST 5'h08
`define BCS_CW_LAST 5'h15
`define BCS_CW_COUNT 14
`define BCS_WORD_COUNT 7
`define BCS_SLOT_W 4
`define BCS_WSEL_W 3
`define BCS_WSEL_MISS 3'h7

// ----------------------------------------
// Per-codeword field layout (low half)
// ----------------------------------------
`define BCS_ENTRY_W 11
`define BCS_F_ERRF 0
`define BCS_F_DONE 1
`define BCS_F_FAIL 2
`define BCS_F_CNT_LO 3
`define BCS_F_CNT_HI 9
`define BCS_F_ERASED 10
`define BCS_CNT_W 7
`define BCS_HALF_W 16
`define BCS_RSVD_W 5
`define BCS_READY_BIT 31
`define BCS_ENTRY_RST 11'h000

// ----------------------------------------
// Interrupt layout
// ----------------------------------------
`define BCS_INT_W 5
`define BCS_I_DONE 0
`define BCS_I_FAIL 1
`define BCS_I_ERRF 2
`define BCS_I_ERASED 3
`define BCS_I_READY 4
`define BCS_INT_RST 5'h00
`define BCS_READY_RST 1'h1

`endif

// *** hdl/bcs_ahb_slave.v ***
// AHB-Lite slave front end: address phase capture, strobes, OKAY answer.
// Assumes a single master, word transfers, and no wait states needed.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.vh"

module bcs_ahb_slave (
  // Clock and reset
  input wire clk,
  input wire rst,
  // AHB-Lite slave side
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  // Register side
  output wire rd_take,
  output wire [`BCS_ADDR_W-1:0] rd_addr,
  output reg wr_strobe,
  output reg [`BCS_ADDR_W-1:0] wr_addr
);

  // ----------------------------------------
  // Address phase
  // ----------------------------------------
  wire take;
  assign take = hsel & hready & htrans[1] & (hsize == `BCS_HSIZE_WORD);
  assign rd_take = take & ~hwrite;
  assign rd_addr = haddr[`BCS_ADDR_W-1:0];

  // ----------------------------------------
  // Data phase and answer
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= `BCS_RESP_OKAY;
      wr_strobe <= 1'b0;
      wr_addr <= {`BCS_ADDR_W{1'b0}};
    end else begin
      hreadyout <= 1'b1;
      hresp <= `BCS_RESP_OKAY;
      wr_strobe <= take & hwrite;
      if (take & hwrite) begin
        wr_addr <= haddr[`BCS_ADDR_W-1:0];
      end
    end
  end

endmodule
`default_nettype wire

// *** hdl/bcs_status_bank.v ***
// Codeword status bank of the raw_flash_controller BCH decoder, AHB-Lite slave.
// Assumes the decoder core reports one codeword at a time on the update port.
//
// Summary of operation
// - Even codeword in low half, odd in high; bits 31:27 (30:27 in the first word), 15:11 read zero.
// - Status words at consecutive words, pair 8/9 at 0x160 to 20/21 at 0x178.
// - Erased flag, bits 10 and 26, set when codeword is all 0xFF bytes.
// - Seven-bit error count at bits 9:3 and 25:19, reset zero.
// - Uncorrectable bit at 2 and 18: one when decoding failed.
// - Finished bit at 1 and 17: one once decoding completed.
// - Errors-found bit at 0 and 16: one when any error detected.
// - First word bit 31 shows decoder ready, zero while busy.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.vh"

module bcs_status_bank (
  // Clock and reset
  input wire clk,
  input wire rst,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Interrupt
  output reg irq,
  // Decoder core
  input wire dec_busy,
  input wire dec_clear,
  input wire upd_valid,
  input wire [4:0] upd_index,
  input wire upd_done,
  input wire upd_fail,
  input wire upd_errf,
  input wire [6:0] upd_count,
  input wire upd_erased
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function in_bank;
    input [4:0] idx;
    begin
      in_bank = (idx >= `BCS_CW_FIRST) && (idx <= `BCS_CW_LAST);
    end
  endfunction

  function [`BCS_SLOT_W-1:0] slot_of;
    input [4:0] idx;
    reg [4:0] diff;
    begin
      diff = idx - `BCS_CW_FIRST;
      slot_of = diff[`BCS_SLOT_W-1:0];
    end
  endfunction

  function [`BCS_WSEL_W-1:0] word_sel;
    input [`BCS_ADDR_W-1:0] addr;
    begin
      case (addr)
        `BCS_OFF_CW_8_9: word_sel = 3'h0;
        `BCS_OFF_CW_10_11: word_sel = 3'h1;
        `BCS_OFF_CW_12_13: word_sel = 3'h2;
        `BCS_OFF_CW_14_15: word_sel = 3'h3;
        `BCS_OFF_CW_16_17: word_sel = 3'h4;
        `BCS_OFF_CW_18_19: word_sel = 3'h5;
        `BCS_OFF_CW_20_21: word_sel = 3'h6;
        default: word_sel = `BCS_WSEL_MISS;
      endcase
    end
  endfunction

  function [`BCS_HALF_W-1:0] half_of;
    input [`BCS_ENTRY_W-1:0] entry;
    begin
      half_of = {{`BCS_RSVD_W{1'b0}}, entry};
    end
  endfunction

  function [`BCS_ENTRY_W-1:0] pack_entry;
    input done;
    input fail;
    input errf;
    input [`BCS_CNT_W-1:0] cnt;
    input erased;
    reg [`BCS_ENTRY_W-1:0] e;
    begin
      e = `BCS_ENTRY_RST;
      e[`BCS_F_ERRF] = errf;
      e[`BCS_F_DONE] = done;
      e[`BCS_F_FAIL] = fail;
      e[`BCS_F_CNT_HI:`BCS_F_CNT_LO] = cnt;
      e[`BCS_F_ERASED] = erased;
      pack_entry = e;
    end
  endfunction

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  wire rd_take;
  wire [`BCS_ADDR_W-1:0] rd_addr;
  wire wr_strobe;
  wire [`BCS_ADDR_W-1:0] wr_addr;

  bcs_ahb_slave u_slave (
    .clk(clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rd_take(rd_take),
    .rd_addr(rd_addr),
    .wr_strobe(wr_strobe),
    .wr_addr(wr_addr)
  );

  // ----------------------------------------
  // Codeword storage
  // ----------------------------------------
  reg [`BCS_ENTRY_W-1:0] cw_mem [0:`BCS_CW_COUNT-1];
  wire upd_hit;
  wire [`BCS_SLOT_W-1:0] upd_slot;
  wire [`BCS_ENTRY_W-1:0] upd_entry;
  integer i;

  assign upd_hit = upd_valid & in_bank(upd_index);
  assign upd_slot = slot_of(upd_index);
  assign upd_entry = pack_entry(upd_done, upd_fail, upd_errf, upd_count, upd_erased);

  always @(posedge clk) begin
    if (rst || dec_clear) begin
      for (i = 0; i < `BCS_CW_COUNT; i = i + 1) begin
        cw_mem[i] <= `BCS_ENTRY_RST;
      end
    end else if (upd_hit) begin
      cw_mem[upd_slot] <= upd_entry;
    end
  end

  // ----------------------------------------
  // Decoder ready indication
  // ----------------------------------------
  reg ready_reg;
  wire ready_next;
  wire ready_rise;

  assign ready_next = ~dec_busy;
  assign ready_rise = ready_next & ~ready_reg;

  always @(posedge clk) begin
    if (rst) begin
      ready_reg <= `BCS_READY_RST;
    end else begin
      ready_reg <= ready_next;
    end
  end

  // ----------------------------------------
  // Status word assembly
  // ----------------------------------------
  wire [31:0] word_data [0:`BCS_WORD_COUNT-1];

  genvar w;
  generate
    for (w = 0; w < `BCS_WORD_COUNT; w = w + 1) begin : g_word
      wire [31:0] pair;
      assign pair = {half_of(cw_mem[2*w+1]), half_of(cw_mem[2*w])};
      if (w == 0) begin : g_first
        assign word_data[w] = {ready_reg, pair[`BCS_READY_BIT-1:0]};
      end else begin : g_rest
        assign word_data[w] = pair;
      end
    end
  endgenerate

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  reg [`BCS_INT_W-1:0] int_status_reg;
  reg [`BCS_INT_W-1:0] int_status_next;
  reg [`BCS_INT_W-1:0] int_mask_reg;
  reg [`BCS_INT_W-1:0] int_mask_next;
  reg [`BCS_INT_W-1:0] int_events;
  wire status_read;

  assign status_read = rd_take && (rd_addr == `BCS_OFF_INT_STATUS);

  always @* begin
    int_events = `BCS_INT_RST;
    int_events[`BCS_I_DONE] = upd_hit & upd_done;
    int_events[`BCS_I_FAIL] = upd_hit & upd_fail;
    int_events[`BCS_I_ERRF] = upd_hit & upd_errf;
    int_events[`BCS_I_ERASED] = upd_hit & upd_erased;
    int_events[`BCS_I_READY] = ready_rise;
  end

  always @* begin
    int_status_next = int_status_reg;
    if (status_read) begin
      int_status_next = `BCS_INT_RST;
    end
    int_status_next = int_status_next | int_events;
  end

  always @* begin
    int_mask_next = int_mask_reg;
    if (wr_strobe && (wr_addr == `BCS_OFF_INT_MASK)) begin
      int_mask_next = hwdata[`BCS_INT_W-1:0];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      int_status_reg <= `BCS_INT_RST;
      int_mask_reg <= `BCS_INT_RST;
      irq <= 1'b0;
    end else begin
      int_status_reg <= int_status_next;
      int_mask_reg <= int_mask_next;
      irq <= |(int_status_next & int_mask_next);
    end
  end

  // ----------------------------------------
  // Read data mux
  // ----------------------------------------
  reg [31:0] rd_data;
  reg [`BCS_WSEL_W-1:0] rd_sel;

  always @* begin
    rd_sel = word_sel(rd_addr);
    rd_data = 32'h0000_0000;
    if (rd_sel != `BCS_WSEL_MISS) begin
      rd_data = word_data[rd_sel];
    end else if (rd_addr == `BCS_OFF_INT_STATUS) begin
      rd_data = {{(32-`BCS_INT_W){1'b0}}, int_status_reg};
    end else if (rd_addr == `BCS_OFF_INT_MASK) begin
      rd_data = {{(32-`BCS_INT_W){1'b0}}, int_mask_reg};
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= rd_data;
    end
  end

endmodule
`default_nettype wire

// *** dv/bcs_status_bank_asserts.sv ***
// Checker for the codeword status bank, top ports only.
// Assumes hready is looped back from hreadyout.
`timescale 1ns/1ps
`default_nettype none
module bcs_status_bank_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Decoder core
  input wire logic dec_busy,
  input wire logic dec_clear,
  input wire logic upd_valid,
  input wire logic [4:0] upd_index,
  input wire logic upd_done,
  input wire logic upd_fail,
  input wire logic upd_errf,
  input wire logic [6:0] upd_count,
  input wire logic upd_erased
);
  // ----------------------------------------
  // Taken read and its offset
  // ----------------------------------------
  wire tk = hsel && hready && htrans[1] && !hwrite && hsize == 3'h2;
  wire [11:0] a = haddr[11:0];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ready_out_a: assert property (hreadyout) else $error("hreadyout low");
  okay_resp_a: assert property (!hresp) else $error("hresp not okay");
  rsvd_zero_a: assert property (
    tk && a >= 12'h0164 && a <= 12'h0178 |=> hrdata[31:27] == 0 && hrdata[15:11] == 0)
    else $error("reserved bits set");
  unmapped_zero_a: assert property (tk && a == 12'h017c |=> hrdata == 0)
    else $error("unmapped read not zero");
  ready_bit_a: assert property (
    tk && a == 12'h0160 && $stable(dec_busy) && !$past(rst) |=> hrdata[31] == !$past(dec_busy))
    else $error("ready bit wrong");
  clear_zero_a: assert property (dec_clear ##1 (tk && a == 12'h0164) |=> hrdata == 0)
    else $error("cleared word not zero");
  even_entry_a: assert property (
    upd_valid && upd_index == 5'h0c && !dec_clear ##1 (tk && a == 12'h0168) |=> hrdata[10:0] ==
    {$past(upd_erased, 2), $past(upd_count, 2), $past(upd_fail, 2), $past(upd_done, 2), $past(upd_errf, 2)})
    else $error("even entry wrong");
  odd_entry_a: assert property (
    upd_valid && upd_index == 5'h0d && !dec_clear ##1 (tk && a == 12'h0168) |=> hrdata[26:16] ==
    {$past(upd_erased, 2), $past(upd_count, 2), $past(upd_fail, 2), $past(upd_done, 2), $past(upd_errf, 2)})
    else $error("odd entry wrong");
endmodule
`default_nettype wire

// *** dv/bcs_status_bank_tb.sv ***
// Self-checking bench for the codeword status bank over AHB-Lite.
// Assumes one slave, so hready is hreadyout.
`timescale 1ns/1ps
`default_nettype none
module bcs_status_bank_tb;
  // ----------------------------------------
  // Signals and model
  // ----------------------------------------
  logic clk, rst, hsel, hwrite, hreadyout, hresp, irq, dec_busy, dec_clear, upd_valid;
  logic upd_done, upd_fail, upd_errf, upd_erased;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] upd_index;
  logic [6:0] upd_count;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [10:0] m [8:21];
  int n_errors, samples_checked, k;

  bcs_status_bank uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq), .dec_busy(dec_busy), .dec_clear(dec_clear),
    .upd_valid(upd_valid), .upd_index(upd_index), .upd_done(upd_done), .upd_fail(upd_fail),
    .upd_errf(upd_errf), .upd_count(upd_count), .upd_erased(upd_erased));

  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task results;
    if (n_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task hw;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (hreadyout === 1'b1)
        return;
    end
    n_errors++;
    results;
  endtask

  task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    upd_valid <= 0;
    dec_clear <= 0;
    haddr <= {20'h0_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hw;
    htrans <= 2'h0;
    hwdata <= wd;
    hw;
    d = hrdata;
  endtask

  task upd(input int i, input logic [10:0] f, input logic b);
    @(posedge clk);
    upd_valid <= 1;
    upd_index <= i[4:0];
    {upd_erased, upd_count, upd_fail, upd_done, upd_errf} <= f;
    dec_busy <= b;
    if (i >= 8 && i <= 21)
      m[i] = f;
  endtask

  function automatic logic [31:0] exp_word(input int e);
    return {~dec_busy & (e == 8), 4'h0, m[e + 1], 5'h00, m[e]};
  endfunction

  task rdk(input int e);
    xfer(0, 12'h0160 + 12'(2 * (e - 8)), 32'h0000_0000);
    chk(d, exp_word(e));
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1;
    hsel = 1;
    hsize = 3'h2;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hwdata = 0;
    dec_busy = 0;
    dec_clear = 0;
    upd_valid = 0;
    upd_index = 0;
    {upd_erased, upd_count, upd_fail, upd_done, upd_errf} = 0;
    n_errors = 0;
    samples_checked = 0;
    foreach (m[i]) m[i] = 0;
    void'($urandom(32'h92f2_9ad9));
    repeat (20) @(posedge clk);
    rst <= 0;
    for (k = 8; k <= 21; k += 2) rdk(k);
    for (k = 8; k <= 21; k++) upd(k, 11'h7ff, 0);
    for (k = 8; k <= 21; k += 2) rdk(k);
    upd(12, 11'h3fa, 1);
    rdk(12);
    upd(13, 11'h405, 1);
    rdk(12);
    repeat (60) begin
      k = $urandom_range(31, 0);
      upd(k, 11'($urandom), 1'($urandom));
      k = (k < 8 || k > 21) ? 8 : k & ~1;
      rdk(k);
    end
    xfer(1, 12'h0164, 32'hffff_ffff);
    rdk(10);
    xfer(0, 12'h017c, 32'h0000_0000);
    chk(d, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    @(posedge clk);
    dec_clear <= 1;
    foreach (m[i]) m[i] = 0;
    rdk(10);
    upd(30, 11'h000, 0);
    xfer(0, 12'h01f0, 32'h0000_0000);
    xfer(0, 12'h01f0, 32'h0000_0000);
    xfer(1, 12'h01f4, 32'h0000_0001);
    xfer(0, 12'h01f4, 32'h0000_0000);
    chk(d, 32'h0000_0001);
    upd(9, 11'h002, 0);
    rdk(8);
    chk({31'h0, d[17]}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0001);
    hsize <= 3'h0;
    xfer(0, 12'h01f4, 32'h0000_0000);
    hsize <= 3'h2;
    chk(d, exp_word(8));
    hsel <= 0;
    xfer(0, 12'h01f0, 32'h0000_0000);
    hsel <= 1;
    chk(d, exp_word(8));
    xfer(0, 12'h01f0, 32'h0000_0000);
    chk(d, 32'h0000_0001);
    xfer(0, 12'h01f0, 32'h0000_0000);
    chk(d, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    results;
  end
endmodule

bind bcs_status_bank bcs_status_bank_asserts chk_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .dec_busy(dec_busy), .dec_clear(dec_clear), .upd_valid(upd_valid),
  .upd_index(upd_index), .upd_done(upd_done), .upd_fail(upd_fail), .upd_errf(upd_errf),
  .upd_count(upd_count), .upd_erased(upd_erased));
`default_nettype wire
